// >>> src/dsp_pkg.sv
/*
  dsp_pkg: shared constants, register offsets, field positions and the
  packed carriers used by the cyclic sync pulse unit.
  assumes byte-wide register accesses with a 12-bit byte address.
*/
package dsp_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_ACT        = 12'h981;
  localparam logic [11:0] OFF_PLEN       = 12'h982;
  localparam logic [11:0] OFF_ACT_STAT   = 12'h984;
  localparam logic [11:0] OFF_ACK0       = 12'h98E;
  localparam logic [11:0] OFF_ACK1       = 12'h98F;
  localparam logic [11:0] OFF_START      = 12'h990;
  localparam logic [11:0] OFF_NEXT2      = 12'h998;
  localparam logic [11:0] OFF_CYC0       = 12'h9A0;
  localparam logic [11:0] OFF_CYC1       = 12'h9A4;
  localparam logic [11:0] SPAN64         = 12'h008;
  localparam logic [11:0] SPAN32         = 12'h004;
  localparam logic [11:0] SPAN16         = 12'h002;

  // activation register fields
  localparam int ACT_UNIT    = 0;
  localparam int ACT_GEN0    = 1;
  localparam int ACT_GEN1    = 2;
  localparam int ACT_AUTO    = 3;
  localparam int ACT_EXT     = 4;
  localparam int ACT_CHECK   = 5;
  localparam int ACT_NEAR    = 6;
  localparam int ACT_DEBUG   = 7;

  // activation status fields
  localparam int STAT_PEND0  = 0;
  localparam int STAT_PEND1  = 1;
  localparam int STAT_OUT    = 2;

  // start time byte indices that complete a load
  localparam logic [2:0] START_LOW_LAST  = 3'h3;
  localparam logic [2:0] START_HIGH_LAST = 3'h7;

  // reset values
  localparam logic [7:0]  ACT_RST   = 8'h00;
  localparam logic [15:0] PLEN_RST  = 16'h0000;
  localparam logic [63:0] TIME_RST  = 64'h0000000000000000;
  localparam logic [31:0] CYC_RST   = 32'h00000000;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // near-future window of the short setting
  localparam logic [63:0] NEAR_SHORT = 64'h0000000080000000;

  // timing: clock period and pulse length step, both in ns
  localparam logic [19:0] CLK_PERIOD_NS = 20'h00004;
  localparam logic [19:0] PULSE_STEP_NS = 20'h0000A;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dsp_bus_req_t;

  typedef struct packed {
    logic        sync;
    logic [19:0] ns;
  } dsp_chan_t;

  typedef struct packed {
    logic [7:0]  act;
    logic [15:0] plen;
    logic [2:0]  act_stat;
    logic [63:0] start;
    logic [63:0] next_first;
    logic [63:0] next_second;
    logic [31:0] cyc0;
    logic [31:0] cyc1;
    logic        running;
    logic        armed;
    logic [7:0]  net_rdata;
    logic [7:0]  host_rdata;
  } dsp_state_t;

endpackage

// >>> src/dsp_sync_chan.sv
/*
  dsp_sync_chan: one sync output channel; stretches a fire strobe to the
  programmed pulse length, or holds it until acknowledged in ack mode.
  assumes a 250 MHz clock and a pulse length in 10 ns steps.
*/
`timescale 1ns/1ps
module dsp_sync_chan (
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic        i_fire,
  input  wire logic [15:0] i_len,
  input  wire logic        i_ack_clr,
  output logic             o_sync
);

  dsp_pkg::dsp_chan_t st;
  dsp_pkg::dsp_chan_t next_st;
  logic [19:0]        len_ns;

  always_comb begin
    len_ns  = {4'h0, i_len} * dsp_pkg::PULSE_STEP_NS;
    next_st = st;
    if (i_fire) begin
      next_st.sync = 1'b1;
      next_st.ns   = dsp_pkg::CLK_PERIOD_NS;
    end else if (st.sync) begin
      if (i_len == dsp_pkg::PLEN_RST) begin
        if (i_ack_clr) begin
          next_st.sync = 1'b0;
        end
      end else if (st.ns >= len_ns) begin
        next_st.sync = 1'b0;
      end else begin
        next_st.ns = st.ns + dsp_pkg::CLK_PERIOD_NS;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_sync = st.sync;

endmodule

// >>> src/dsp_sync_unit.sv
/*
  dsp_sync_unit: cyclic sync output unit of the distributed time base.
  compares start and cycle times with the system time and drives the
  first and second sync outputs; byte registers reachable from the
  network side and the local host interface.
  assumes the system time counter, the cyclic unit control register and
  the eeprom loader live outside and feed this block synchronously.
*/
`timescale 1ns/1ps
module dsp_sync_unit (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_ce,
  input  wire logic [63:0]           i_system_time,
  input  wire logic                  i_sync_ctrl_host,
  input  wire logic                  i_plen_load,
  input  wire logic [15:0]           i_plen_value,
  input  wire dsp_pkg::dsp_bus_req_t i_net_req,
  input  wire dsp_pkg::dsp_bus_req_t i_host_req,
  output logic [7:0]                 o_net_rdata,
  output logic [7:0]                 o_host_rdata,
  output logic                       o_first_sync_output,
  output logic                       o_second_sync_output
);

  dsp_pkg::dsp_state_t   st;
  dsp_pkg::dsp_state_t   next_st;
  dsp_pkg::dsp_bus_req_t wreq;
  logic                  wr_ok;
  logic                  debug_fire;
  logic                  first_due;
  logic                  second_due;
  logic                  act_rise;
  logic                  outside;
  logic                  fire0;
  logic                  fire1;
  logic                  ack_clr0;
  logic                  ack_clr1;
  logic [63:0]           start_diff;
  logic [63:0]           due_diff0;
  logic [63:0]           due_diff1;
  logic [11:0]           wofs;
  logic [2:0]            wbyte;
  logic                  load_done;
  logic                  first_sync_output_q;
  logic                  second_sync_output_q;

  // byte read mux shared by both access sides
  function automatic logic [7:0] read_byte(input dsp_pkg::dsp_state_t s,
                                           input logic [11:0] a,
                                           input logic s0,
                                           input logic s1);
    logic [11:0] o;
    logic [7:0]  b;
    o = 12'h000;
    b = dsp_pkg::BYTE_ZERO;
    if (a == dsp_pkg::OFF_ACT) begin
      b = s.act;
    end else if (a >= dsp_pkg::OFF_PLEN && a < dsp_pkg::OFF_PLEN + dsp_pkg::SPAN16) begin
      o = a - dsp_pkg::OFF_PLEN;
      b = s.plen[8*o[0] +: 8];
    end else if (a == dsp_pkg::OFF_ACT_STAT) begin
      b = {5'h00, s.act_stat};
    end else if (a == dsp_pkg::OFF_ACK0) begin
      b = {7'h00, s0};
    end else if (a == dsp_pkg::OFF_ACK1) begin
      b = {7'h00, s1};
    end else if (a >= dsp_pkg::OFF_START && a < dsp_pkg::OFF_START + dsp_pkg::SPAN64) begin
      o = a - dsp_pkg::OFF_START;
      b = s.next_first[8*o[2:0] +: 8];
    end else if (a >= dsp_pkg::OFF_NEXT2 && a < dsp_pkg::OFF_NEXT2 + dsp_pkg::SPAN64) begin
      o = a - dsp_pkg::OFF_NEXT2;
      b = s.next_second[8*o[2:0] +: 8];
    end else if (a >= dsp_pkg::OFF_CYC0 && a < dsp_pkg::OFF_CYC0 + dsp_pkg::SPAN32) begin
      o = a - dsp_pkg::OFF_CYC0;
      b = s.cyc0[8*o[1:0] +: 8];
    end else if (a >= dsp_pkg::OFF_CYC1 && a < dsp_pkg::OFF_CYC1 + dsp_pkg::SPAN32) begin
      o = a - dsp_pkg::OFF_CYC1;
      b = s.cyc1[8*o[1:0] +: 8];
    end
    return b;
  endfunction

  always_comb begin
    next_st    = st;
    wreq       = i_sync_ctrl_host ? i_host_req : i_net_req;
    wr_ok      = i_ce & wreq.wr;
    debug_fire = 1'b0;
    act_rise   = 1'b0;
    load_done  = 1'b0;
    wofs       = 12'h000;
    wbyte      = 3'h0;
    fire0      = 1'b0;
    fire1      = 1'b0;

    // register writes from the controlling side only
    if (wr_ok) begin
      if (wreq.addr == dsp_pkg::OFF_ACT) begin
        next_st.act = {1'b0, wreq.wdata[6:0]};
        debug_fire  = wreq.wdata[dsp_pkg::ACT_DEBUG];
      end else if (wreq.addr >= dsp_pkg::OFF_START &&
                   wreq.addr < dsp_pkg::OFF_START + dsp_pkg::SPAN64) begin
        wofs  = wreq.addr - dsp_pkg::OFF_START;
        wbyte = wofs[2:0];
        next_st.start[8*wbyte +: 8] = wreq.wdata;
        if (wbyte == dsp_pkg::START_HIGH_LAST) begin
          load_done = 1'b1;
        end else if (wbyte == dsp_pkg::START_LOW_LAST &&
                     (st.act[dsp_pkg::ACT_EXT] | st.act[dsp_pkg::ACT_AUTO])) begin
          load_done = 1'b1;
          next_st.start[63:32] = i_system_time[63:32];
          if (next_st.start[31:0] < i_system_time[31:0]) begin
            next_st.start[63:32] = i_system_time[63:32] + 32'h00000001;
          end
        end
        if (load_done && st.act[dsp_pkg::ACT_AUTO]) begin
          next_st.act[dsp_pkg::ACT_UNIT] = 1'b1;
        end
      end else if (wreq.addr >= dsp_pkg::OFF_CYC0 &&
                   wreq.addr < dsp_pkg::OFF_CYC0 + dsp_pkg::SPAN32) begin
        wofs = wreq.addr - dsp_pkg::OFF_CYC0;
        next_st.cyc0[8*wofs[1:0] +: 8] = wreq.wdata;
      end else if (wreq.addr >= dsp_pkg::OFF_CYC1 &&
                   wreq.addr < dsp_pkg::OFF_CYC1 + dsp_pkg::SPAN32) begin
        wofs = wreq.addr - dsp_pkg::OFF_CYC1;
        next_st.cyc1[8*wofs[1:0] +: 8] = wreq.wdata;
      end
    end

    // pulse length only changes by the eeprom load
    if (i_ce && i_plen_load) begin
      next_st.plen = i_plen_value;
    end

    // window check against the start time about to take effect
    start_diff = next_st.start - i_system_time;
    if (next_st.act[dsp_pkg::ACT_NEAR]) begin
      outside = start_diff >= dsp_pkg::NEAR_SHORT;
    end else begin
      outside = start_diff[63];
    end

    due_diff0  = i_system_time - st.next_first;
    due_diff1  = i_system_time - st.next_second;
    first_due  = i_ce & st.running & ~due_diff0[63];
    second_due = i_ce & st.armed & ~due_diff1[63];

    if (i_ce) begin
      act_rise = next_st.act[dsp_pkg::ACT_UNIT] & ~st.act[dsp_pkg::ACT_UNIT];
      if (!next_st.act[dsp_pkg::ACT_UNIT]) begin
        next_st.running  = 1'b0;
        next_st.armed    = 1'b0;
        next_st.act_stat[dsp_pkg::STAT_PEND0] = 1'b0;
        next_st.act_stat[dsp_pkg::STAT_PEND1] = 1'b0;
      end else if (act_rise) begin
        next_st.act_stat[dsp_pkg::STAT_OUT] = outside;
        if (next_st.act[dsp_pkg::ACT_CHECK] && outside) begin
          next_st.next_first = i_system_time;
        end else begin
          next_st.next_first = next_st.start;
        end
        next_st.running = 1'b1;
        next_st.armed   = 1'b0;
        next_st.act_stat[dsp_pkg::STAT_PEND0] = 1'b1;
        next_st.act_stat[dsp_pkg::STAT_PEND1] = 1'b1;
      end else begin
        if (first_due) begin
          fire0               = st.act[dsp_pkg::ACT_GEN0];
          next_st.next_second = st.next_first + {32'h00000000, st.cyc1};
          next_st.armed       = 1'b1;
          next_st.act_stat[dsp_pkg::STAT_PEND0] = 1'b0;
          if (st.cyc0 == dsp_pkg::CYC_RST) begin
            next_st.running = 1'b0;
          end else begin
            next_st.next_first = st.next_first + {32'h00000000, st.cyc0};
          end
        end else if (second_due) begin
          fire1         = st.act[dsp_pkg::ACT_GEN1];
          next_st.armed = 1'b0;
          next_st.act_stat[dsp_pkg::STAT_PEND1] = 1'b0;
        end
      end
    end

    if (debug_fire) begin
      fire0 = fire0 | wreq.wdata[dsp_pkg::ACT_GEN0];
      fire1 = fire1 | wreq.wdata[dsp_pkg::ACT_GEN1];
    end

    // registered read data per side
    if (i_ce && i_net_req.rd) begin
      next_st.net_rdata = read_byte(st, i_net_req.addr, first_sync_output_q, second_sync_output_q);
    end
    if (i_ce && i_host_req.rd) begin
      next_st.host_rdata = read_byte(st, i_host_req.addr, first_sync_output_q, second_sync_output_q);
    end
  end

  // acknowledge by host reads only; the channel ignores it outside ack mode
  assign ack_clr0 = i_host_req.rd && i_host_req.addr == dsp_pkg::OFF_ACK0;
  assign ack_clr1 = i_host_req.rd && i_host_req.addr == dsp_pkg::OFF_ACK1;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  dsp_sync_chan u_first_chan (
    .i_mclk    (i_mclk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_fire    (fire0),
    .i_len     (st.plen),
    .i_ack_clr (ack_clr0),
    .o_sync    (first_sync_output_q)
  );

  dsp_sync_chan u_second_chan (
    .i_mclk    (i_mclk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_fire    (fire1),
    .i_len     (st.plen),
    .i_ack_clr (ack_clr1),
    .o_sync    (second_sync_output_q)
  );

  assign o_first_sync_output  = first_sync_output_q;
  assign o_second_sync_output = second_sync_output_q;
  assign o_net_rdata          = st.net_rdata;
  assign o_host_rdata         = st.host_rdata;

  // checks
  chk_debug_pulse: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (wr_ok && wreq.addr == dsp_pkg::OFF_ACT && wreq.wdata[7] && wreq.wdata[1])
      |=> o_first_sync_output)
    else $error("debug write did not raise the first sync output");

  chk_gen_enable: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_second_sync_output) |-> st.act[dsp_pkg::ACT_GEN1])
    else $error("second sync pulse without its enable bit");

  chk_ack_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && st.plen == dsp_pkg::PLEN_RST && o_first_sync_output && !ack_clr0)
      |=> o_first_sync_output)
    else $error("ack mode output dropped without a status read");

  chk_ack_read: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && st.plen == dsp_pkg::PLEN_RST && ack_clr0 && !fire0)
      |=> !o_first_sync_output && o_host_rdata[0] == $past(o_first_sync_output))
    else $error("host status read did not report and clear the output");

  chk_write_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_sync_ctrl_host && i_net_req.wr && !i_host_req.wr) |=> $stable(st.start)
      && $stable(st.cyc0) && $stable(st.cyc1))
    else $error("network write taken while the host owns the unit");

  chk_len_ro: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_plen_load |=> $stable(st.plen))
    else $error("pulse length changed without an eeprom load");

  chk_auto_act: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (load_done && wr_ok && st.act[dsp_pkg::ACT_AUTO]) |=> st.act[dsp_pkg::ACT_UNIT])
    else $error("auto-activation did not set the activation bit");

  chk_outside_flag: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && act_rise) |=> st.act_stat[dsp_pkg::STAT_OUT] == $past(outside))
    else $error("plausibility result not recorded at activation");

  chk_pending_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (first_due && !act_rise && st.act[dsp_pkg::ACT_UNIT] && !wr_ok)
      |=> !st.act_stat[dsp_pkg::STAT_PEND0] ##1 st.armed || !st.act[dsp_pkg::ACT_UNIT]
      || !st.act_stat[dsp_pkg::STAT_PEND1])
    else $error("first pulse pending flag not cleared");

  chk_single_shot: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (first_due && !act_rise && st.cyc0 == dsp_pkg::CYC_RST && !wr_ok) |=> !st.running)
    else $error("single shot mode kept running");

  chk_debug_second: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (wr_ok && wreq.addr == dsp_pkg::OFF_ACT && wreq.wdata[dsp_pkg::ACT_DEBUG]
      && wreq.wdata[dsp_pkg::ACT_GEN1]) |=> o_second_sync_output)
    else $error("debug write did not raise the second sync output");

  chk_first_enable: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_first_sync_output) |-> st.act[dsp_pkg::ACT_GEN0])
    else $error("first sync pulse without its enable bit");

  chk_cycle_advance: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (first_due && !act_rise && !wr_ok && st.act[dsp_pkg::ACT_UNIT] && st.cyc0 != dsp_pkg::CYC_RST)
      |=> st.next_first == $past(st.next_first) + {32'h00000000, $past(st.cyc0)})
    else $error("next first pulse time not advanced by the cycle time");

  chk_second_sched: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (first_due && !act_rise && !wr_ok && st.act[dsp_pkg::ACT_UNIT])
      |=> st.next_second == $past(st.next_first) + {32'h00000000, $past(st.cyc1)})
    else $error("second pulse not scheduled from the first pulse");

  chk_deact_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_ce && !next_st.act[dsp_pkg::ACT_UNIT]) |=> !st.running && !st.armed
      && !st.act_stat[dsp_pkg::STAT_PEND0] && !st.act_stat[dsp_pkg::STAT_PEND1])
    else $error("deactivation left the unit running or pending");

  cov_debug: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    wr_ok && wreq.addr == dsp_pkg::OFF_ACT && wreq.wdata[dsp_pkg::ACT_DEBUG]);
  cov_auto: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    load_done && wr_ok && st.act[dsp_pkg::ACT_AUTO]);
  cov_cyclic: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    first_due && st.cyc0 != dsp_pkg::CYC_RST ##[1:200] first_due);
  cov_second: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(o_second_sync_output));
  cov_ack: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    st.plen == dsp_pkg::PLEN_RST && o_first_sync_output && ack_clr0);

endmodule

// >>> dv/dsp_bus_agent.sv
/*
  dsp_bus_agent: byte access master standing in for the network side or
  the local host interface of the sync unit.
  assumes requests are taken on the rising edge; drives at falling edges.
*/
`timescale 1ns/1ps
module dsp_bus_agent (
  input  wire logic             i_mclk,
  output dsp_pkg::dsp_bus_req_t o_req
);
  initial begin
    o_req = '0;
  end

  // one byte access held over one rising edge; released lines show garbage
  task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_req.wr    = w;
    o_req.rd    = ~w;
    o_req.addr  = a;
    o_req.wdata = d;
    @(negedge i_mclk);
    o_req.wr    = 1'b0;
    o_req.rd    = 1'b0;
    o_req.addr  = ~a;
    o_req.wdata = ~d;
  endtask
endmodule

// >>> dv/dsp_sync_unit_tb.sv
/*
  dsp_sync_unit_tb: self-checking bench for the cyclic sync pulse unit.
  assumes dsp_pkg, dsp_sync_chan, dsp_sync_unit and dsp_bus_agent exist.
*/
`timescale 1ns/1ps
module dsp_sync_unit_tb;
  logic                  i_mclk;
  logic                  i_rstn;
  logic [63:0]           sys;
  logic                  ctrl_host;
  logic                  ce;
  logic                  plen_load;
  logic [15:0]           plen_value;
  dsp_pkg::dsp_bus_req_t net_req;
  dsp_pkg::dsp_bus_req_t host_req;
  logic [7:0]            net_rdata;
  logic [7:0]            host_rdata;
  logic                  first_out;
  logic                  second_out;
  logic [7:0]            qn[$];
  logic [7:0]            qh[$];
  logic [1:0]            sn;
  logic [1:0]            sh;
  int                    bad_count;
  int                    num_checks;
  int                    p0;
  int                    p1;
  int                    w0;
  int                    w1;
  int                    wexp;
  int                    seed;
  int                    b;
  int                    c;
  logic [63:0]           st;
  logic [31:0]           v;

  dsp_bus_agent u_net (.i_mclk(i_mclk), .o_req(net_req));
  dsp_bus_agent u_host (.i_mclk(i_mclk), .o_req(host_req));
  dsp_sync_unit dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(ce), .i_system_time(sys),
    .i_sync_ctrl_host(ctrl_host), .i_plen_load(plen_load), .i_plen_value(plen_value),
    .i_net_req(net_req), .i_host_req(host_req), .o_net_rdata(net_rdata),
    .o_host_rdata(host_rdata), .o_first_sync_output(first_out),
    .o_second_sync_output(second_out)
  );

  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr_n(input logic s, input logic [11:0] a, input logic [63:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      if (s) u_host.access(1'b1, a + 12'(i), d[8*i +: 8]);
      else u_net.access(1'b1, a + 12'(i), d[8*i +: 8]);
    end
  endtask

  // little endian read: expected bytes are queued, the monitor compares
  task automatic rd_n(input logic s, input logic [11:0] a, input logic [63:0] e, input int n);
    for (int i = 0; i < n; i++) begin
      if (s) qh.push_back(e[8*i +: 8]);
      else qn.push_back(e[8*i +: 8]);
      if (s) u_host.access(1'b0, a + 12'(i), 8'h00);
      else u_net.access(1'b0, a + 12'(i), 8'h00);
    end
  endtask

  task automatic wait_cnt(ref int k, input int n, input int lim, input string m);
    for (int i = 0; i < lim && k < n; i++) @(negedge i_mclk);
    cmp(64'(k >= n), 64'h1, m);
  endtask

  task automatic test_end(input string m);
    $display("test %s done at %0t", m, $time);
  endtask

  always @(posedge i_mclk) begin
    sn <= {sn[0], net_req.rd & i_rstn & ce};
    sh <= {sh[0], host_req.rd & i_rstn & ce};
  end

  // read results, pulse counts and widths, system time
  always @(negedge i_mclk) begin
    if (sn[1] === 1'b1) begin
      if (qn.size() == 0) cmp(64'h0, 64'h1, "unexpected net read");
      else cmp(64'(net_rdata), 64'(qn.pop_front()), "net read byte");
    end
    if (sh[1] === 1'b1) begin
      if (qh.size() == 0) cmp(64'h0, 64'h1, "unexpected host read");
      else cmp(64'(host_rdata), 64'(qh.pop_front()), "host read byte");
    end
    if (i_rstn) sys <= sys + 64'(dsp_pkg::CLK_PERIOD_NS);
    if (first_out === 1'b1) w0++;
    else if (w0 != 0) begin
      p0++;
      if (wexp != 0) cmp(64'(w0), 64'(wexp), "first pulse width");
      w0 = 0;
    end
    if (second_out === 1'b1) w1++;
    else if (w1 != 0) begin
      p1++;
      if (wexp != 0) cmp(64'(w1), 64'(wexp), "second pulse width");
      w1 = 0;
    end
  end

  initial begin
    seed = 32'hE7D2;
    i_rstn = 1'b0;
    sys = 64'h0000000310000000;
    ctrl_host = 1'b0;
    ce = 1'b1;
    plen_load = 1'b0;
    plen_value = 16'h0000;
    {sn, sh} = 4'h0;
    {bad_count, num_checks, p0, p1, w0, w1, wexp} = '0;
    repeat (8) @(negedge i_mclk);
    i_rstn = 1'b1;
    for (int a = 12'h981; a <= 12'h9A8; a++) rd_n(1'b0, 12'(a), 64'h0, 1);
    test_end("reset values");
    wr_n(1'b0, dsp_pkg::OFF_ACT, 64'h86, 1);
    repeat (3) @(negedge i_mclk);
    cmp(64'({first_out, second_out}), 64'h3, "ack mode hold");
    ce = 1'b0;
    u_host.access(1'b0, dsp_pkg::OFF_ACK0, 8'h00);
    repeat (2) @(negedge i_mclk);
    cmp(64'({first_out, second_out}), 64'h3, "clock enable freeze");
    ce = 1'b1;
    rd_n(1'b0, dsp_pkg::OFF_ACT, 64'h06, 1);
    rd_n(1'b0, dsp_pkg::OFF_ACK0, 64'h01, 1);
    rd_n(1'b1, dsp_pkg::OFF_ACK0, 64'h01, 1);
    @(negedge i_mclk);
    cmp(64'({first_out, second_out}), 64'h1, "ack clear first");
    rd_n(1'b1, dsp_pkg::OFF_ACK1, 64'h01, 1);
    @(negedge i_mclk);
    cmp(64'({first_out, second_out}), 64'h0, "ack clear second");
    rd_n(1'b1, dsp_pkg::OFF_ACK0, 64'h00, 1);
    test_end("ack mode");
    v = $random(seed);
    wr_n(1'b1, dsp_pkg::OFF_CYC0, 64'(v), 4);
    rd_n(1'b0, dsp_pkg::OFF_CYC0, 64'h0, 4);
    wr_n(1'b0, dsp_pkg::OFF_CYC0, 64'(v), 4);
    rd_n(1'b1, dsp_pkg::OFF_CYC0, 64'(v), 4);
    ctrl_host = 1'b1;
    wr_n(1'b0, dsp_pkg::OFF_CYC1, 64'hFF, 4);
    rd_n(1'b0, dsp_pkg::OFF_CYC1, 64'h0, 4);
    wr_n(1'b1, dsp_pkg::OFF_CYC1, 64'd40, 4);
    rd_n(1'b0, dsp_pkg::OFF_CYC1, 64'd40, 4);
    wr_n(1'b1, dsp_pkg::OFF_PLEN, 64'h0505, 2);
    rd_n(1'b1, dsp_pkg::OFF_PLEN, 64'h0, 2);
    plen_load = 1'b1;
    plen_value = 16'h0002;
    @(negedge i_mclk);
    plen_load = 1'b0;
    rd_n(1'b1, dsp_pkg::OFF_PLEN, 64'h0002, 2);
    wexp = (2 * dsp_pkg::PULSE_STEP_NS + dsp_pkg::CLK_PERIOD_NS - 1) / dsp_pkg::CLK_PERIOD_NS;
    test_end("ownership and layout");
    b = p0;
    c = p1;
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h84, 1);
    wait_cnt(p1, c + 1, 12, "debug pulse second");
    cmp(64'(p0), 64'(b), "debug first gated");
    rd_n(1'b1, dsp_pkg::OFF_ACT, 64'h04, 1);
    test_end("debug pulse");
    v = 32'd400 + ($random(seed) & 32'hFC);
    wr_n(1'b1, dsp_pkg::OFF_CYC0, 64'(v), 4);
    st = sys + 64'd400;
    wr_n(1'b1, dsp_pkg::OFF_START, st, 8);
    b = p0;
    c = p1;
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h07, 1);
    rd_n(1'b1, dsp_pkg::OFF_ACT_STAT, 64'h03, 1);
    wait_cnt(p0, b + 1, 200, "cyclic first pulse");
    rd_n(1'b1, dsp_pkg::OFF_START, st + 64'(v), 8);
    rd_n(1'b0, dsp_pkg::OFF_NEXT2, st + 64'd40, 8);
    wait_cnt(p0, b + 2, 200, "cyclic second pulse");
    cmp(64'(p1), 64'(c + 1), "second output count");
    rd_n(1'b1, dsp_pkg::OFF_ACT_STAT, 64'h00, 1);
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h00, 1);
    test_end("cyclic");
    wr_n(1'b1, dsp_pkg::OFF_CYC0, 64'h0, 4);
    wr_n(1'b1, dsp_pkg::OFF_START, sys - 64'd1000, 8);
    b = p0;
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h23, 1);
    wait_cnt(p0, b + 1, 12, "past start immediate");
    repeat (30) @(negedge i_mclk);
    cmp(64'(p0), 64'(b + 1), "single shot");
    rd_n(1'b1, dsp_pkg::OFF_ACT_STAT, 64'h04, 1);
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h00, 1);
    st = sys + 64'h0000000080000FA0;
    wr_n(1'b1, dsp_pkg::OFF_START, st, 8);
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h63, 1);
    wait_cnt(p0, b + 2, 12, "short window immediate");
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h00, 1);
    wr_n(1'b1, dsp_pkg::OFF_START, st, 8);
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h23, 1);
    repeat (20) @(negedge i_mclk);
    cmp(64'(p0), 64'(b + 2), "long window waits");
    rd_n(1'b1, dsp_pkg::OFF_ACT_STAT, 64'h03, 1);
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h00, 1);
    test_end("plausibility");
    b = p0;
    wr_n(1'b1, dsp_pkg::OFF_ACT, 64'h1A, 1);
    st = sys + 64'd800;
    wr_n(1'b1, dsp_pkg::OFF_START, st, 4);
    rd_n(1'b1, dsp_pkg::OFF_ACT, 64'h1B, 1);
    rd_n(1'b1, dsp_pkg::OFF_START + dsp_pkg::SPAN32, 64'(st[63:32]), 4);
    wait_cnt(p0, b + 1, 250, "auto activation pulse");
    test_end("auto activation");
    give_verdict();
  end

  initial begin
    #80000;
    cmp(64'h0, 64'h1, "watchdog expired");
    give_verdict();
  end
endmodule
